// file: dv/saipc_host_model.sv
// host side of the interrupt pin: a pulled-up line seen by the processor
`timescale 1ns/1ps
`default_nettype none
module saipc_host_model (
    input wire logic irq_pin_o,
    input wire logic irq_pin_oe,
    output logic irq_level
);
    // board pull-up holds the shared line high while no source drives it
    assign irq_level = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule // saipc_host_model
`default_nettype wire

// file: dv/saipc_top_tb_top.sv
// testbench for the sync association and interrupt pin block
`timescale 1ns/1ps
`default_nettype none
module saipc_top_tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    saipc_pkg::saipc_bus_t bus = '0;
    logic [7:0] rdata;
    logic ext_sync_enable = 1'b0;
    logic frame_sync_in = 1'b0;
    logic locked = 1'b0;
    logic [3:0] locked_ref = 4'h0;
    logic frame_sync_accepted, irq, irq_pin_o, irq_pin_oe, irq_level;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    saipc_top uut (.clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata),
        .ext_sync_enable(ext_sync_enable), .frame_sync_in(frame_sync_in),
        .locked(locked), .locked_ref(locked_ref),
        .frame_sync_accepted(frame_sync_accepted), .irq(irq),
        .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));
    saipc_host_model host (.irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
        .irq_level(irq_level));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus <= '0;
        #1 check(rdata, exp);
    endtask
    // pin value, enable and host level packed for one compare
    task automatic pin(input int n, input logic [7:0] exp);
        repeat (n) @(posedge clock);
        #1 check({5'h00, irq_pin_o, irq_pin_oe, irq_level}, exp);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // the run should need well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(saipc_pkg::ADDR_SYNC_CFG, saipc_pkg::SYNC_CFG_RST);
        rd(saipc_pkg::ADDR_IRQ_CFG, saipc_pkg::IRQ_CFG_RST);
        rd(4'h5, saipc_pkg::ZERO8);
        pin(0, 8'h05);
        wr(saipc_pkg::ADDR_IRQ_CFG, 8'h04);
        pin(1, 8'h02);
        wr(saipc_pkg::ADDR_IRQ_CFG, 8'h05);
        pin(1, 8'h07);
        wr(saipc_pkg::ADDR_IRQ_CFG, 8'h00);
        pin(1, 8'h07);
        @(posedge clock);
        ext_sync_enable <= 1'b1;
        locked <= 1'b1;
        frame_sync_in <= 1'b1;
        // every code: only 1..14 follow a matching lock
        for (int c = 0; c < 16; c++) begin
            wr(saipc_pkg::ADDR_SYNC_CFG, {4'h2, c[3:0]});
            locked_ref <= c[3:0];
            repeat (4) @(posedge clock);
            #1 check({7'h00, frame_sync_accepted}, {7'h00, (c > 0 && c < 15)});
        end
        wr(saipc_pkg::ADDR_SYNC_CFG, 8'h03);
        locked_ref <= 4'h4;
        repeat (4) @(posedge clock);
        #1 check({7'h00, frame_sync_accepted}, 8'h00);
        @(posedge clock);
        locked_ref <= 4'h3;
        locked <= 1'b0;
        repeat (4) @(posedge clock);
        #1 check({7'h00, frame_sync_accepted}, 8'h00);
        @(posedge clock);
        locked <= 1'b1;
        repeat (4) @(posedge clock);
        #1 check({7'h00, frame_sync_accepted}, 8'h01);
        rd(saipc_pkg::ADDR_STATUS, 8'h03);
        rd(saipc_pkg::ADDR_LOCK, 8'h13);
        wr(saipc_pkg::ADDR_STATUS, 8'h03);
        wr(saipc_pkg::ADDR_MASK, 8'h01);
        pin(1, 8'h07);
        @(posedge clock);
        frame_sync_in <= 1'b0;
        repeat (4) @(posedge clock);
        frame_sync_in <= 1'b1;
        pin(5, 8'h02);
        check({7'h00, irq}, 8'h01);
        rd(saipc_pkg::ADDR_STATUS, 8'h01);
        rd(saipc_pkg::ADDR_MASK, 8'h01);
        wr(saipc_pkg::ADDR_IRQ_CFG, 8'hfb);
        pin(1, 8'h07);
        rd(saipc_pkg::ADDR_IRQ_CFG, 8'h03);
        wr(saipc_pkg::ADDR_STATUS, 8'h01);
        pin(2, 8'h01);
        check({7'h00, irq}, 8'h00);
        summarize();
    end
endmodule // saipc_top_tb_top
`default_nettype wire

// file: rtl/saipc_pkg.sv
// package for the sync association and interrupt pin configuration block
package saipc_pkg;
    localparam logic [3:0] ADDR_SYNC_CFG = 4'h0;
    localparam logic [3:0] ADDR_IRQ_CFG = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_LOCK = 4'h4;
    localparam logic [7:0] SYNC_CFG_RST = 8'h2b;
    localparam logic [7:0] IRQ_CFG_RST = 8'h02;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [3:0] ASSOC_NONE = 4'h0;
    localparam logic [3:0] ASSOC_LAST = 4'he;
    localparam int ASSOC_LSB = 0;
    localparam int ASSOC_MSB = 3;
    localparam int POL_BIT = 0;
    localparam int TRI_BIT = 1;
    localparam int GPO_BIT = 2;
    localparam int NUM_EVT = 2;
    localparam int EVT_SYNC_OK = 0;
    localparam int EVT_SYNC_DROP = 1;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } saipc_bus_t;
endpackage : saipc_pkg

// file: rtl/saipc_top.sv
// sync association and interrupt pin configuration register block
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - four bit association code: 0 none, 1..14 select reference inputs 1..14
// - with sync enabled, accept frame sync only while locked to selected reference
// - bit 2 picks pin function: 0 interrupt output, 1 general output
// - in general output mode pin drives the polarity bit's level
// - bit 1: 0 pin always driven, 1 driven only when active in interrupt mode (general output mode always drives)
// - polarity 0 active low interrupt, 1 active high
module saipc_top (
    input wire logic clock,
    input wire logic rstn,
    input wire saipc_pkg::saipc_bus_t bus,
    output logic [7:0] rdata,
    input wire logic ext_sync_enable,
    input wire logic frame_sync_in,
    input wire logic locked,
    input wire logic [3:0] locked_ref,
    output logic frame_sync_accepted,
    output logic irq,
    output logic irq_pin_o,
    output logic irq_pin_oe
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_s1_q, rst_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // frame sync is an asynchronous pin; lock status comes from on-clock logic
    logic fs_s1_q, fs_s2_q;
    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            fs_s1_q <= 1'b0;
            fs_s2_q <= 1'b0;
        end else begin
            fs_s1_q <= frame_sync_in;
            fs_s2_q <= fs_s1_q;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] sync_cfg_q, sync_cfg_d, irq_cfg_q, irq_cfg_d;
    logic [saipc_pkg::NUM_EVT-1:0] status_q, status_d, mask_q, mask_d, evt;
    logic [7:0] rdata_q, rdata_d;
    logic fs_acc_q, fs_acc_d, irq_q, irq_d, pin_q, pin_d, oe_q, oe_d, fs_prev_q;
    logic [3:0] assoc;
    logic assoc_valid, ref_match, active;

    always_comb begin
        assoc = sync_cfg_q[saipc_pkg::ASSOC_MSB:saipc_pkg::ASSOC_LSB];
        assoc_valid = (assoc != saipc_pkg::ASSOC_NONE) && (assoc <= saipc_pkg::ASSOC_LAST);
        ref_match = assoc_valid && locked && (locked_ref == assoc);
    end

    always_comb begin
        sync_cfg_d = sync_cfg_q;
        irq_cfg_d = irq_cfg_q;
        mask_d = mask_q;
        status_d = status_q;
        rdata_d = saipc_pkg::ZERO8;
        // gate frame sync on selected lock; no lock, pulse ignored
        fs_acc_d = ext_sync_enable && fs_s2_q && ref_match;
        evt[saipc_pkg::EVT_SYNC_OK] = fs_acc_d && !fs_prev_q;
        evt[saipc_pkg::EVT_SYNC_DROP] = ext_sync_enable && fs_s2_q && !ref_match;
        if (bus.wr) begin
            unique case (bus.addr)
                saipc_pkg::ADDR_SYNC_CFG: sync_cfg_d = bus.wdata;
                saipc_pkg::ADDR_IRQ_CFG: begin
                    // unused bits 7:3 are not stored, so they read back as zero
                    irq_cfg_d = saipc_pkg::ZERO8;
                    irq_cfg_d[saipc_pkg::GPO_BIT:saipc_pkg::POL_BIT] =
                        bus.wdata[saipc_pkg::GPO_BIT:saipc_pkg::POL_BIT];
                end
                saipc_pkg::ADDR_STATUS: status_d = status_q & ~bus.wdata[saipc_pkg::NUM_EVT-1:0];
                saipc_pkg::ADDR_MASK: mask_d = bus.wdata[saipc_pkg::NUM_EVT-1:0];
                default: ;
            endcase
        end
        // set wins over clear
        status_d = status_d | evt;
        if (bus.rd) begin
            unique case (bus.addr)
                saipc_pkg::ADDR_SYNC_CFG: rdata_d = sync_cfg_q;
                saipc_pkg::ADDR_IRQ_CFG: rdata_d = irq_cfg_q;
                saipc_pkg::ADDR_STATUS: rdata_d = {6'h0_0, status_q};
                saipc_pkg::ADDR_MASK: rdata_d = {6'h0_0, mask_q};
                saipc_pkg::ADDR_LOCK: rdata_d = {3'h0, locked, locked_ref};
                default: rdata_d = saipc_pkg::ZERO8;
            endcase
        end
        irq_d = |(status_d & mask_d);
        active = irq_d;
        if (irq_cfg_d[saipc_pkg::GPO_BIT]) begin
            pin_d = irq_cfg_d[saipc_pkg::POL_BIT];
            oe_d = 1'b1;
        end else begin
            // polarity 0 drives low when active
            pin_d = irq_cfg_d[saipc_pkg::POL_BIT] ? active : !active;
            oe_d = !irq_cfg_d[saipc_pkg::TRI_BIT] || active;
        end
    end

    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            sync_cfg_q <= saipc_pkg::SYNC_CFG_RST;
            irq_cfg_q <= saipc_pkg::IRQ_CFG_RST;
            status_q <= '0;
            mask_q <= '0;
            rdata_q <= saipc_pkg::ZERO8;
            fs_acc_q <= 1'b0;
            fs_prev_q <= 1'b0;
            irq_q <= 1'b0;
            pin_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            sync_cfg_q <= sync_cfg_d;
            irq_cfg_q <= irq_cfg_d;
            status_q <= status_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            fs_acc_q <= fs_acc_d;
            fs_prev_q <= fs_acc_d;
            irq_q <= irq_d;
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    assign rdata = rdata_q;
    assign frame_sync_accepted = fs_acc_q;
    assign irq = irq_q;
    assign irq_pin_o = pin_q;
    assign irq_pin_oe = oe_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // no accept without lock match
    a_sync_gate_lock: assert property (@(posedge clock) disable iff (!rst_q)
        frame_sync_accepted |-> $past(ref_match) && $past(ext_sync_enable))
        else $error("frame sync accepted without matching lock");
    a_assoc_none: assert property (@(posedge clock) disable iff (!rst_q)
        ($past(assoc) == 4'hf || $past(assoc) == 4'h0) |-> !frame_sync_accepted)
        else $error("frame sync accepted with no association");
    // valid code and matching lock accepts
    a_assoc_select: assert property (@(posedge clock) disable iff (!rst_q)
        (ext_sync_enable && fs_s2_q && locked && locked_ref == assoc && assoc != 4'h0
         && assoc != 4'hf) |=> frame_sync_accepted)
        else $error("associated frame sync not accepted");
    a_gpo_level: assert property (@(posedge clock) disable iff (!rst_q)
        $past(irq_cfg_d[2]) |-> irq_pin_oe && irq_pin_o == $past(irq_cfg_d[0]))
        else $error("general output level wrong");
    a_pin_func: assert property (@(posedge clock) disable iff (!rst_q)
        (!irq_cfg_q[2] && irq_pin_oe) |-> (irq_pin_o == (irq_cfg_q[0] ? irq : !irq)))
        else $error("interrupt pin level wrong");
    a_tristate_idle: assert property (@(posedge clock) disable iff (!rst_q)
        (!irq_cfg_q[2] && irq_cfg_q[1] && !irq) |-> !irq_pin_oe)
        else $error("pin driven while inactive in tristate mode");
    a_always_drive: assert property (@(posedge clock) disable iff (!rst_q)
        (!irq_cfg_q[1]) |-> irq_pin_oe)
        else $error("pin not driven in push-pull mode");
    a_pol_low: assert property (@(posedge clock) disable iff (!rst_q)
        (!irq_cfg_q[2] && !irq_cfg_q[0] && irq) |-> irq_pin_oe && !irq_pin_o)
        else $error("active low interrupt not driven low");
    a_pol_high: assert property (@(posedge clock) disable iff (!rst_q)
        (!irq_cfg_q[saipc_pkg::GPO_BIT] && irq_cfg_q[saipc_pkg::POL_BIT] && irq)
        |-> irq_pin_oe && irq_pin_o)
        else $error("active high interrupt not driven high");
    // inactive level is the inverse of the polarity
    a_pol_idle: assert property (@(posedge clock) disable iff (!rst_q)
        (!irq_cfg_q[saipc_pkg::GPO_BIT] && !irq_cfg_q[saipc_pkg::TRI_BIT] && !irq)
        |-> irq_pin_oe && (irq_pin_o == !irq_cfg_q[saipc_pkg::POL_BIT]))
        else $error("inactive interrupt pin level wrong");
    a_oe_active: assert property (@(posedge clock) disable iff (!rst_q)
        (!irq_cfg_q[saipc_pkg::GPO_BIT] && irq) |-> irq_pin_oe)
        else $error("active interrupt pin not driven");
    // sync use disabled blocks the input
    a_sync_disabled: assert property (@(posedge clock) disable iff (!rst_q)
        !ext_sync_enable |=> !frame_sync_accepted)
        else $error("frame sync accepted while sync use disabled");
    a_lock_required: assert property (@(posedge clock) disable iff (!rst_q)
        !locked |=> !frame_sync_accepted)
        else $error("frame sync accepted while unlocked");
    // accepted sync raises its status bit
    a_status_set: assert property (@(posedge clock) disable iff (!rst_q)
        $rose(frame_sync_accepted) |-> status_q[saipc_pkg::EVT_SYNC_OK])
        else $error("accepted sync did not set status");
    // ignored sync raises its status bit
    a_drop_event: assert property (@(posedge clock) disable iff (!rst_q)
        (ext_sync_enable && fs_s2_q && !ref_match) |=> status_q[saipc_pkg::EVT_SYNC_DROP])
        else $error("ignored sync did not set status");
    a_status_sticky: assert property (@(posedge clock) disable iff (!rst_q)
        ($past(status_q[saipc_pkg::EVT_SYNC_OK]) && !($past(bus.wr)
         && $past(bus.addr) == saipc_pkg::ADDR_STATUS)) |-> status_q[saipc_pkg::EVT_SYNC_OK])
        else $error("status bit lost without a clear");
endmodule // saipc_top
`default_nettype wire
